// >>> core/rftps_map.svh
/*
 * Constants for the transmitter power-up sequencer: timing figures and
 * derived cycle counts, channel field layout.
 * Assumes a 125 MHz system clock.
 */
`ifndef RFTPS_MAP_SVH
`define RFTPS_MAP_SVH

`define RFTPS_CLK_KHZ 125000
`define RFTPS_TICK_US 1000
`define RFTPS_TICK_CYCLES (`RFTPS_CLK_KHZ * `RFTPS_TICK_US / 1000)
`define RFTPS_PON_DELAY_MS 7
`define RFTPS_LOCK_TIMEOUT_MS 15
`define RFTPS_CH_W 3
`define RFTPS_CH_RESET 3'h0

`endif

// >>> core/rftps_pkg.sv
/*
 * Types shared by the sequencer files.
 * Assumes the map header is compiled alongside.
 */
package rftps_pkg;

	typedef enum logic [2:0] {
		RFTPS_OFF = 3'h0,
		RFTPS_PON = 3'h1,
		RFTPS_SAMPLE = 3'h3,
		RFTPS_PROGRAM = 3'h2,
		RFTPS_LOCKWAIT = 3'h6,
		RFTPS_READY = 3'h7
	} rftps_state_e;

	typedef struct packed {
		logic load;
		logic [2:0] channel;
		logic enable;
	} rftps_synth_s;

endpackage

// >>> core/rftps_tick.sv
/*
 * Millisecond tick divider: one-cycle enable pulse every tick period.
 * Assumes a 125 MHz clock; restarts whenever clear is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rftps_map.svh"

module rftps_tick #(
	parameter int unsigned TICK_N = `RFTPS_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clear,
	output logic tick
);
	logic [16:0] cnt_reg;
	logic [16:0] cnt_next;
	wire logic at_end = (cnt_reg == 17'(TICK_N - 1));

	assign cnt_next = (clear || at_end) ? 17'h00000 : cnt_reg + 17'h00001;
	assign tick = at_end && !clear;

	always_ff @(posedge clk) begin
		if (reset)
			cnt_reg <= 17'h00000;
		else
			cnt_reg <= cnt_next;
	end
endmodule
`default_nettype wire

// >>> core/rftps_sequencer.sv
/*
 * Power-up sequencer for a channelised radio transmitter: waits a
 * power-on delay, latches the channel select pins, loads the synthesizer
 * and raises clear-to-send once lock is reported.
 * Assumes all inputs are synchronous to clk; power_down_n defaults high
 * through an external pull-up; synth_lock comes from the synthesizer.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rftps_map.svh"

module rftps_sequencer #(
	parameter int unsigned PON_DELAY_MS = `RFTPS_PON_DELAY_MS,
	parameter int unsigned LOCK_TIMEOUT_MS = `RFTPS_LOCK_TIMEOUT_MS,
	parameter int unsigned TICK_CYCLES = `RFTPS_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic power_down_n,
	input wire logic channel_select_bit0,
	input wire logic channel_select_bit1,
	input wire logic channel_select_bit2,
	input wire logic synth_lock,
	output rftps_pkg::rftps_synth_s synth,
	output logic tx_enable,
	output logic clear_to_send,
	output logic [2:0] state_dbg
);
	// ****************************************
	// State and timing
	// ****************************************
	rftps_pkg::rftps_state_e state_reg;
	rftps_pkg::rftps_state_e state_next;
	logic pdn_prev_reg;
	logic pdn_prev_next;
	logic [7:0] ms_reg;
	logic [7:0] ms_next;
	logic [`RFTPS_CH_W-1:0] chan_reg;
	logic [`RFTPS_CH_W-1:0] chan_next;
	logic load_reg;
	logic load_next;
	logic cts_reg;
	logic cts_next;
	logic tick;

	// ****************************************
	// Input and state decode
	// ****************************************
	wire logic powered = power_down_n;
	wire logic wake = power_down_n && !pdn_prev_reg;
	wire logic [`RFTPS_CH_W-1:0] chan_pins = {channel_select_bit2, channel_select_bit1, channel_select_bit0};
	wire logic in_off = (state_reg == rftps_pkg::RFTPS_OFF);
	wire logic in_pon = (state_reg == rftps_pkg::RFTPS_PON);
	wire logic in_sample = (state_reg == rftps_pkg::RFTPS_SAMPLE);
	wire logic in_program = (state_reg == rftps_pkg::RFTPS_PROGRAM);
	wire logic in_lockwait = (state_reg == rftps_pkg::RFTPS_LOCKWAIT);
	wire logic in_timed = in_pon || in_lockwait;
	// Tick restarts on entry to a timed state, so the first millisecond is whole
	wire logic tick_clear = !in_timed || wake;
	// Counts whole ticks from entry, so the delay is exactly PON_DELAY_MS ticks
	wire logic pon_done = in_pon && tick && (ms_reg == 8'(PON_DELAY_MS - 1));
	// Lock lost or never reached: start again rather than hang with CTS low
	wire logic lock_expired = in_lockwait && tick
		&& (ms_reg == 8'(LOCK_TIMEOUT_MS - 1));
	// Lock seen in the load cycle still belongs to the old setting
	wire logic lock_fresh = synth_lock && !load_reg;
	wire logic lock_lost = !synth_lock;

	// ****************************************
	// Channel capture
	// ****************************************
	// One flop per select pin, held outside the sample state
	for (genvar i = 0; i < `RFTPS_CH_W; i++) begin : g_chan
		assign chan_next[i] = in_sample ? chan_pins[i] : chan_reg[i];
	end

	// ****************************************
	// Millisecond tick
	// ****************************************
	rftps_tick #(
		.TICK_N(TICK_CYCLES)
	) u_tick (
		.clk(clk),
		.reset(reset),
		.clear(tick_clear),
		.tick(tick)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			rftps_pkg::RFTPS_OFF: begin
				if (powered) begin
					state_next = rftps_pkg::RFTPS_PON;
				end
			end
			rftps_pkg::RFTPS_PON: begin
				if (pon_done) begin
					state_next = rftps_pkg::RFTPS_SAMPLE;
				end
			end
			rftps_pkg::RFTPS_SAMPLE: begin
				state_next = rftps_pkg::RFTPS_PROGRAM;
			end
			rftps_pkg::RFTPS_PROGRAM: begin
				state_next = rftps_pkg::RFTPS_LOCKWAIT;
			end
			rftps_pkg::RFTPS_LOCKWAIT: begin
				if (lock_fresh) begin
					state_next = rftps_pkg::RFTPS_READY;
				end else if (lock_expired) begin
					state_next = rftps_pkg::RFTPS_SAMPLE;
				end
			end
			rftps_pkg::RFTPS_READY: begin
				if (lock_lost) begin
					state_next = rftps_pkg::RFTPS_LOCKWAIT;
				end
			end
			default: begin
				state_next = rftps_pkg::RFTPS_OFF;
			end
		endcase
		if (!powered) begin
			state_next = rftps_pkg::RFTPS_OFF;
		end else if (wake) begin
			state_next = rftps_pkg::RFTPS_PON;
		end
	end

	// ****************************************
	// Next register values
	// ****************************************
	assign pdn_prev_next = power_down_n;
	assign ms_next = (tick_clear || state_next != state_reg) ? 8'h00
		: (tick ? ms_reg + 8'h01 : ms_reg);
	// A restart in the program cycle would load a channel that is about to go stale
	assign load_next = in_program && powered && !wake;
	// Taken from the next state so CTS and READY change on one edge
	assign cts_next = (state_next == rftps_pkg::RFTPS_READY);

	// ****************************************
	// Sequencer registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= rftps_pkg::RFTPS_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pdn_prev_reg <= 1'b0; // Reset acts as supply-on: a high pin then starts a sequence
		end else begin
			pdn_prev_reg <= pdn_prev_next;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ms_reg <= 8'h00;
		end else begin
			ms_reg <= ms_next;
		end
	end

	// ****************************************
	// Synthesizer control
	// ****************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			chan_reg <= `RFTPS_CH_RESET;
		end else begin
			chan_reg <= chan_next;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			load_reg <= 1'b0;
		end else begin
			load_reg <= load_next;
		end
	end

	// ****************************************
	// Clear to send
	// ****************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			cts_reg <= 1'b0;
		end else begin
			cts_reg <= cts_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign tx_enable = !in_off;
	assign synth = '{load: load_reg, channel: chan_reg, enable: tx_enable};
	assign clear_to_send = cts_reg;
	assign state_dbg = state_reg;
endmodule
`default_nettype wire

// >>> test/rftps_chk.sv
/* Port checker for the sequencer.
Bound to the top module from the bench. */
`timescale 1ns/1ps
`default_nettype none
module rftps_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic power_down_n,
	input wire logic channel_select_bit0,
	input wire logic channel_select_bit1,
	input wire logic channel_select_bit2,
	input wire logic synth_lock,
	input wire rftps_pkg::rftps_synth_s synth,
	input wire logic tx_enable,
	input wire logic clear_to_send,
	input wire logic [2:0] state_dbg
);
	wire logic [2:0] ch = {channel_select_bit2, channel_select_bit1, channel_select_bit0};
	default clocking dc @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_prog;
		state_dbg == 3'h3 ##1 state_dbg == 3'h2 && power_down_n;
	endsequence
	off_holds_a: assert property (!power_down_n |=> !tx_enable && !clear_to_send)
		else $error("active while off");
	wake_run_a: assert property ($past(reset) && power_down_n |=> state_dbg == 3'h1)
		else $error("no start after supply");
	restart_a: assert property ($rose(power_down_n) |=> state_dbg == 3'h1)
		else $error("no restart");
	prog_load_a: assert property (s_prog |=> synth.load && state_dbg == 3'h6)
		else $error("no load after sample");
	load_chan_a: assert property (synth.load |-> synth.channel == $past(ch, 2))
		else $error("wrong channel");
	load_once_a: assert property (synth.load |=> !synth.load)
		else $error("load too long");
	cts_lock_a: assert property ($rose(clear_to_send) |-> $past(synth_lock) && $past(state_dbg) == 3'h6)
		else $error("ready without lock");
	lock_fresh_a: assert property ($rose(clear_to_send) |-> !$past(synth.load))
		else $error("ready on stale lock");
	cts_drop_a: assert property (clear_to_send && !synth_lock |=> !clear_to_send)
		else $error("ready kept after unlock");
	cts_state_a: assert property (clear_to_send |-> state_dbg == 3'h7 && tx_enable)
		else $error("ready outside ready state");
endmodule
`default_nettype wire

// >>> test/rftps_synth_model.sv
/* Synthesizer model: lock a set number of cycles after a load.
Driven by the sequencer's synthesizer struct. */
`timescale 1ns/1ps
`default_nettype none
module rftps_synth_model (
	input wire logic clk,
	input wire logic reset,
	input wire rftps_pkg::rftps_synth_s synth,
	input wire logic [7:0] delay,
	input wire logic lose,
	output logic synth_lock
);
	logic [7:0] cnt_reg;
	logic armed_reg;
	// Lock lost on power-off or reprogramming; an unloaded loop never locks
	always_ff @(posedge clk) begin
		if (reset || !synth.enable || synth.load) begin
			cnt_reg <= delay;
			synth_lock <= 1'b0;
			armed_reg <= synth.load && synth.enable && !reset;
		end else if (cnt_reg != 8'h0) begin
			cnt_reg <= cnt_reg - 8'h1;
		end else begin
			synth_lock <= !lose && armed_reg;
		end
	end
endmodule
`default_nettype wire

// >>> test/rftps_sequencer_bench.sv
/* Bench for the sequencer and a synthesizer model.
Tick shortened to 50 cycles so every millisecond figure stays short. */
`timescale 1ns/1ps
`default_nettype none
module rftps_sequencer_bench;
	localparam int TICK = 50;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic power_down_n = 1'b1;
	logic [2:0] ch = 3'h5;
	logic [7:0] delay = 8'h1;
	logic lose = 1'b0;
	logic synth_lock, tx_enable, clear_to_send;
	logic [2:0] state_dbg;
	rftps_pkg::rftps_synth_s synth;
	int failures = 0;
	int n_checks = 0;
	initial forever #4 clk = !clk;
	rftps_sequencer #(.TICK_CYCLES(TICK)) dut_u (.clk(clk), .reset(reset), .power_down_n(power_down_n),
		.channel_select_bit0(ch[0]), .channel_select_bit1(ch[1]), .channel_select_bit2(ch[2]),
		.synth_lock(synth_lock), .synth(synth), .tx_enable(tx_enable), .clear_to_send(clear_to_send),
		.state_dbg(state_dbg));
	rftps_synth_model model_u (.clk(clk), .reset(reset), .synth(synth), .delay(delay), .lose(lose),
		.synth_lock(synth_lock));
	task automatic check(input logic [4:0] got, input logic [4:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wait_for(input logic [1:0] what);
		for (int i = 0; i < 4000; i++) begin
			@(posedge clk);
			#1;
			if (what == 2'h1 && synth.load === 1'b1) return;
			if (what == 2'h0 && clear_to_send === 1'b1) return;
			if (what == 2'h2 && state_dbg === 3'h3) return;
		end
		failures++;
		give_verdict();
	endtask
	task automatic start_seq(input logic [2:0] c);
		wait_for(2'h1);
		check(synth, {1'b1, c, 1'b1});
		check({4'h0, clear_to_send}, 5'h0);
		wait_for(2'h0);
		check({synth_lock, 1'b0, state_dbg}, 5'h17);
	endtask
	// Lock held off past the timeout, then back just as the channel is resampled
	task automatic relock(input logic [2:0] c);
		lose = 1'b1;
		ch = c;
		wait_for(2'h2);
		lose = 1'b0;
		wait_for(2'h1);
		check(synth, {1'b1, c, 1'b1});
		check({3'h0, synth_lock, clear_to_send}, 5'h2);
		wait_for(2'h0);
		check({synth_lock, 1'b0, state_dbg}, 5'h17);
	endtask
	task automatic blind_start();
		power_down_n = 1'b1;
		@(posedge clk);
		#1 check({3'h0, tx_enable, clear_to_send}, 5'h2);
		repeat (10 * TICK - 1) @(posedge clk);
		#1 check({4'h0, clear_to_send}, 5'h1);
		repeat (40 * TICK) @(posedge clk);
		#1 check({4'h0, clear_to_send}, 5'h1);
	endtask
	task automatic lock_loss();
		lose = 1'b1;
		repeat (3) @(posedge clk);
		#1 check({4'h0, clear_to_send}, 5'h0);
		lose = 1'b0;
		repeat (4) @(posedge clk);
		#1 check({4'h0, clear_to_send}, 5'h1);
	endtask
	task automatic power_off();
		power_down_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 check({clear_to_send, tx_enable, state_dbg}, 5'h0);
		repeat (TICK) @(posedge clk);
		#1 check({clear_to_send, tx_enable, state_dbg}, 5'h0);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1 check({clear_to_send, tx_enable, state_dbg}, 5'h0);
		reset = 1'b0;
		start_seq(3'h5);
		lock_loss();
		power_off();
		ch = 3'h2;
		delay = 8'h28;
		power_down_n = 1'b1;
		start_seq(3'h2);
		relock(3'h7);
		power_off();
		blind_start();
		give_verdict();
	end
endmodule
bind rftps_sequencer rftps_chk chk_u (.clk(clk), .reset(reset), .power_down_n(power_down_n),
	.channel_select_bit0(channel_select_bit0), .channel_select_bit1(channel_select_bit1),
	.channel_select_bit2(channel_select_bit2), .synth_lock(synth_lock), .synth(synth),
	.tx_enable(tx_enable), .clear_to_send(clear_to_send), .state_dbg(state_dbg));
`default_nettype wire
